// ===== design/adm_regs.vh
// Register indices, field positions, reset values and counts for the
// audio DAC mode control bank. Definitions only.
`ifndef ADM_REGS_VH
`define ADM_REGS_VH

`define ADM_WORD_BITS      5'h10
`define ADM_IDX_DONE       5'h08
`define ADM_RW_BIT         15

`define ADM_IDX_MUTE16     7'h07
`define ADM_IDX_DIS16      7'h08
`define ADM_IDX_FMT        7'h09
`define ADM_IDX_FLAG       7'h0a
`define ADM_IDX_READ       7'h0b
`define ADM_IDX_OVER       7'h0c
`define ADM_IDX_MUTE78     7'h12
`define ADM_IDX_DIS78      7'h13

`define ADM_FMT_ROLLOFF    5
`define ADM_FMT_CLKDIV     4
`define ADM_FMT_CLKOFF     3
`define ADM_FLAG_ZPOL      6
`define ADM_FLAG_PHASE     5
`define ADM_READ_INC       7
`define ADM_OVER_BIT       7

`define ADM_RST_MUTE16     6'h00
`define ADM_RST_MUTE78     2'h0
`define ADM_RST_DIS16      6'h00
`define ADM_RST_DIS78      2'h0
`define ADM_RST_FMT        6'h00
`define ADM_RST_FLAG       7'h00
`define ADM_RST_READ       8'h01
`define ADM_RST_OVER       8'h00

`define ADM_ATT_FULL       8'hff
`define ADM_ATT_MUTE       8'h80
`define ADM_ZERO_RUN       1024

`endif

// ===== design/adm_chan.v
// One output channel: soft-mute attenuation ramp and zero-run detector.
// Assumes step and sample ticks are one-cycle pulses on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "adm_regs.vh"

module adm_chan #(
	parameter ZERO_RUN = `ADM_ZERO_RUN
) (
	input  wire       clk_i,
	input  wire       rst_n_i,
	input  wire       mute_i,
	input  wire [7:0] target_i,
	input  wire       step_tick_i,
	input  wire       sample_tick_i,
	input  wire       data_zero_i,
	output reg  [7:0] level_o,
	output reg        zero_o
);
	reg  [10:0] run_q;
	wire [7:0]  goal;
	wire        tgt_mute;

	// Any target at or below the mute code behaves as full mute
	assign tgt_mute = (target_i <= `ADM_ATT_MUTE);
	assign goal     = (mute_i | tgt_mute) ? `ADM_ATT_MUTE : target_i;

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			level_o <= `ADM_ATT_FULL;
		end else if (step_tick_i) begin
			if (level_o > goal)
				level_o <= level_o - 8'h01;
			else if (level_o < goal)
				level_o <= level_o + 8'h01;
		end
	end

	// Counter saturates so a long silence never wraps the flag off
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_q  <= 11'h000;
			zero_o <= 1'b0;
		end else if (sample_tick_i) begin
			if (!data_zero_i) begin
				run_q  <= 11'h000;
				zero_o <= 1'b0;
			end else if (run_q < ZERO_RUN[10:0]) begin
				run_q  <= run_q + 11'h001;
				zero_o <= (run_q == ZERO_RUN[10:0] - 11'h001);
			end
		end
	end
endmodule // adm_chan
`default_nettype wire

// ===== design/adm_bank.v
// Mode control bank of an eight-channel audio DAC with its serial port.
// Assumes serial pins are asynchronous and slow against the system clock.
`timescale 1ns/10ps
`default_nettype none
`include "adm_regs.vh"

module adm_bank #(
	parameter ZERO_RUN = `ADM_ZERO_RUN
) (
	input  wire        CLK_SYS_I,
	input  wire        RST_N_I,
	input  wire        LATCH_N_I,
	input  wire        SER_CLK_I,
	input  wire        SER_DATA_I,
	output reg         SER_DATA_O,
	output reg         SER_DATA_OE_O,
	input  wire [63:0] ATTEN_TARGET_I,
	input  wire        STEP_TICK_I,
	input  wire        SAMPLE_TICK_I,
	input  wire [7:0]  CHANNEL_ZERO_I,
	output wire [63:0] ATTEN_LEVEL_O,
	output reg  [7:0]  CHANNEL_OUTPUT_DISABLE_O,
	output reg         FILTER_ROLLOFF_SELECT_O,
	output reg  [2:0]  AUDIO_FORMAT_SELECT_O,
	output reg         OUTPUT_PHASE_INVERT_O,
	output reg  [1:0]  DEEMPH_RATE_SELECT_O,
	output reg         DEEMPH_ENABLE_O,
	output reg         OVERSAMPLE_O,
	output reg  [7:0]  ZERO_FLAG_O,
	output reg         ZERO_ALL_O,
	output wire        SYSTEM_CLOCK_OUTPUT_O
);
	reg  [5:0]  mute16_q;
	reg  [1:0]  mute78_q;
	reg  [5:0]  dis16_q;
	reg  [1:0]  dis78_q;
	reg  [5:0]  fmt_q;
	reg  [6:0]  flag_q;
	reg  [7:0]  read_q;
	reg  [7:0]  over_q;
	reg  [2:0]  latch_s_q;
	reg  [2:0]  sclk_s_q;
	reg  [2:0]  sdat_s_q;
	reg         latch_f_q;
	reg         sclk_f_q;
	reg         sdat_f_q;
	reg         sclk_prev_q;
	reg  [15:0] shift_q;
	reg  [4:0]  cnt_q;
	reg  [7:0]  out_q;
	reg  [6:0]  ptr_q;
	reg         rd_q;
	reg         div_q;
	reg         clk_off_q;
	reg         clk_div_q;
	wire [7:0]  zero_raw;
	wire [15:0] word_d;
	wire        sclk_rise;
	wire        sclk_fall;
	wire        in_frame;
	wire        auto_inc;
	wire        zero_pol;

	// Readback decode; unmapped indices answer zero
	function [7:0] rd_mux;
		input [6:0] idx;
		begin
			case (idx)
				`ADM_IDX_MUTE16: rd_mux = {2'b00, mute16_q};
				`ADM_IDX_MUTE78: rd_mux = {6'h00, mute78_q};
				`ADM_IDX_DIS16:  rd_mux = {2'b00, dis16_q};
				`ADM_IDX_DIS78:  rd_mux = {6'h00, dis78_q};
				`ADM_IDX_FMT:    rd_mux = {2'b00, fmt_q};
				`ADM_IDX_FLAG:   rd_mux = {1'b0, flag_q};
				`ADM_IDX_READ:   rd_mux = read_q;
				`ADM_IDX_OVER:   rd_mux = over_q;
				default:         rd_mux = 8'h00;
			endcase
		end
	endfunction

	// Three-stage synchronisers; a level counts once stages two and three agree
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			latch_s_q   <= 3'b111;
			sclk_s_q    <= 3'b000;
			sdat_s_q    <= 3'b000;
			latch_f_q   <= 1'b1;
			sclk_f_q    <= 1'b0;
			sdat_f_q    <= 1'b0;
			sclk_prev_q <= 1'b0;
		end else begin
			latch_s_q   <= {latch_s_q[1:0], LATCH_N_I};
			sclk_s_q    <= {sclk_s_q[1:0], SER_CLK_I};
			sdat_s_q    <= {sdat_s_q[1:0], SER_DATA_I};
			if (latch_s_q[1] == latch_s_q[2])
				latch_f_q <= latch_s_q[2];
			if (sclk_s_q[1] == sclk_s_q[2])
				sclk_f_q <= sclk_s_q[2];
			if (sdat_s_q[1] == sdat_s_q[2])
				sdat_f_q <= sdat_s_q[2];
			sclk_prev_q <= sclk_f_q;
		end
	end

	assign in_frame  = ~latch_f_q;
	assign sclk_rise = in_frame & sclk_f_q & ~sclk_prev_q;
	assign sclk_fall = in_frame & ~sclk_f_q & sclk_prev_q;
	assign word_d    = {shift_q[14:0], sdat_f_q};
	assign auto_inc  = read_q[`ADM_READ_INC];

	// Serial frame: bit count, shift, read pointer and readback data
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			shift_q <= 16'h0000;
			cnt_q   <= 5'h00;
			out_q   <= 8'h00;
			ptr_q   <= 7'h00;
			rd_q    <= 1'b0;
		end else if (!in_frame) begin
			cnt_q <= 5'h00;
			rd_q  <= 1'b0;
		end else if (sclk_rise) begin
			shift_q <= word_d;
			if (cnt_q == `ADM_IDX_DONE - 5'h01) begin
				cnt_q <= `ADM_IDX_DONE;
				rd_q  <= word_d[7];
				if (word_d[7]) begin
					// Burst starts at the addressed index, single read at the read index
					ptr_q <= auto_inc ? word_d[6:0] : read_q[6:0];
					out_q <= rd_mux(auto_inc ? word_d[6:0] : read_q[6:0]);
				end
			end else if (cnt_q == `ADM_WORD_BITS - 5'h01) begin
				if (rd_q && auto_inc && ptr_q != read_q[6:0]) begin
					cnt_q <= `ADM_IDX_DONE;
					ptr_q <= ptr_q + 7'h01;
					out_q <= rd_mux(ptr_q + 7'h01);
				end else begin
					cnt_q <= `ADM_WORD_BITS;
				end
			end else if (cnt_q != `ADM_WORD_BITS) begin
				cnt_q <= cnt_q + 5'h01;
				if (cnt_q >= `ADM_IDX_DONE)
					out_q <= {out_q[6:0], 1'b0};
			end
		end
	end

	// Read data driven only in the data half of a read word
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			SER_DATA_O    <= 1'b0;
			SER_DATA_OE_O <= 1'b0;
		end else if (!in_frame) begin
			SER_DATA_OE_O <= 1'b0;
			SER_DATA_O    <= 1'b0;
		end else if (sclk_fall) begin
			SER_DATA_OE_O <= rd_q && cnt_q >= `ADM_IDX_DONE && cnt_q != `ADM_WORD_BITS;
			SER_DATA_O    <= out_q[7];
		end
	end

	// Register writes on the last bit of a write word; reserved bits are dropped
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			mute16_q <= `ADM_RST_MUTE16;
			mute78_q <= `ADM_RST_MUTE78;
			dis16_q  <= `ADM_RST_DIS16;
			dis78_q  <= `ADM_RST_DIS78;
			fmt_q    <= `ADM_RST_FMT;
			flag_q   <= `ADM_RST_FLAG;
			read_q   <= `ADM_RST_READ;
			over_q   <= `ADM_RST_OVER;
		end else if (sclk_rise && cnt_q == `ADM_WORD_BITS - 5'h01 && !rd_q
				&& !shift_q[`ADM_RW_BIT - 1]) begin
			// Index from the full word, as shift_q still lags one bit here
			case (word_d[14:8])
				`ADM_IDX_MUTE16: mute16_q <= word_d[5:0];
				`ADM_IDX_MUTE78: mute78_q <= word_d[1:0];
				`ADM_IDX_DIS16:  dis16_q  <= word_d[5:0];
				`ADM_IDX_DIS78:  dis78_q  <= word_d[1:0];
				`ADM_IDX_FMT:    fmt_q    <= word_d[5:0];
				`ADM_IDX_FLAG:   flag_q   <= word_d[6:0];
				`ADM_IDX_READ:   read_q   <= word_d[7:0];
				`ADM_IDX_OVER:   over_q   <= word_d[7:0];
				default: ;
			endcase
		end
	end

	// Channels: ramp and zero detection
	genvar ch;
	generate
		for (ch = 0; ch < 8; ch = ch + 1) begin : g_ch
			wire mute_bit;
			assign mute_bit = (ch < 6) ? mute16_q[ch % 6] : mute78_q[ch % 2];
			adm_chan #(
				.ZERO_RUN      (ZERO_RUN)
			) u_chan (
				.clk_i         (CLK_SYS_I),
				.rst_n_i       (RST_N_I),
				.mute_i        (mute_bit),
				.target_i      (ATTEN_TARGET_I[ch*8 +: 8]),
				.step_tick_i   (STEP_TICK_I),
				.sample_tick_i (SAMPLE_TICK_I),
				.data_zero_i   (CHANNEL_ZERO_I[ch]),
				.level_o       (ATTEN_LEVEL_O[ch*8 +: 8]),
				.zero_o        (zero_raw[ch])
			);
		end
	endgenerate

	assign zero_pol = flag_q[`ADM_FLAG_ZPOL];

	// Mode outputs registered from the bank
	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			CHANNEL_OUTPUT_DISABLE_O <= 8'h00;
			FILTER_ROLLOFF_SELECT_O  <= 1'b0;
			AUDIO_FORMAT_SELECT_O    <= 3'h0;
			OUTPUT_PHASE_INVERT_O    <= 1'b0;
			DEEMPH_RATE_SELECT_O     <= 2'h0;
			DEEMPH_ENABLE_O          <= 1'b0;
			OVERSAMPLE_O             <= 1'b0;
			ZERO_FLAG_O              <= 8'h00;
			ZERO_ALL_O               <= 1'b0;
		end else begin
			CHANNEL_OUTPUT_DISABLE_O <= {dis78_q, dis16_q};
			FILTER_ROLLOFF_SELECT_O  <= fmt_q[`ADM_FMT_ROLLOFF];
			AUDIO_FORMAT_SELECT_O    <= fmt_q[2:0];
			OUTPUT_PHASE_INVERT_O    <= flag_q[`ADM_FLAG_PHASE];
			DEEMPH_RATE_SELECT_O     <= flag_q[4:3];
			DEEMPH_ENABLE_O          <= |flag_q[2:0];
			OVERSAMPLE_O             <= over_q[`ADM_OVER_BIT];
			ZERO_FLAG_O              <= zero_raw ^ {8{zero_pol}};
			ZERO_ALL_O               <= (&zero_raw) ^ zero_pol;
		end
	end

	// Clock output; controls retimed on the falling edge to keep the mux glitch-free
	always @(negedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			clk_off_q <= 1'b0;
			clk_div_q <= 1'b0;
		end else begin
			clk_off_q <= fmt_q[`ADM_FMT_CLKOFF];
			clk_div_q <= fmt_q[`ADM_FMT_CLKDIV];
		end
	end

	always @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I)
			div_q <= 1'b0;
		else
			div_q <= ~div_q;
	end

	// Full rate passes the input clock straight through
	assign SYSTEM_CLOCK_OUTPUT_O = clk_off_q ? 1'b0 :
		(clk_div_q ? div_q : CLK_SYS_I);
endmodule // adm_bank
`default_nettype wire

// ===== tb/adm_bank_assertions.sv
// Port checker for the audio DAC mode control bank.
// Assumes one clock domain; bound to every adm_bank instance.
`timescale 1ns/10ps
`default_nettype none
module adm_bank_chk #(
	parameter ZERO_RUN = 1024
) (
	input wire logic        CLK_SYS_I,
	input wire logic        RST_N_I,
	input wire logic        LATCH_N_I,
	input wire logic        SER_CLK_I,
	input wire logic        STEP_TICK_I,
	input wire logic        SER_DATA_O,
	input wire logic        SER_DATA_OE_O,
	input wire logic [63:0] ATTEN_LEVEL_O,
	input wire logic [7:0]  CHANNEL_OUTPUT_DISABLE_O,
	input wire logic [2:0]  AUDIO_FORMAT_SELECT_O,
	input wire logic        DEEMPH_ENABLE_O,
	input wire logic [7:0]  ZERO_FLAG_O,
	input wire logic        ZERO_ALL_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);
	property p_rst;
		$rose(RST_N_I) |-> ATTEN_LEVEL_O == '1 && CHANNEL_OUTPUT_DISABLE_O == 8'h00
			&& AUDIO_FORMAT_SELECT_O == 3'h0 && !DEEMPH_ENABLE_O;
	endproperty
	a_rst: assert property (p_rst) else $error("Defaults missing after reset");
	property p_hold;
		!$past(STEP_TICK_I) |-> $stable(ATTEN_LEVEL_O);
	endproperty
	a_hold: assert property (p_hold) else $error("Level moved without tick");
	property p_step;
		$past(STEP_TICK_I) && $changed(ATTEN_LEVEL_O[7:0]) |->
			($past(ATTEN_LEVEL_O[7:0]) - ATTEN_LEVEL_O[7:0] == 8'h01)
			|| (ATTEN_LEVEL_O[7:0] - $past(ATTEN_LEVEL_O[7:0]) == 8'h01);
	endproperty
	a_step: assert property (p_step) else $error("Level step not one");
	property p_floor;
		ATTEN_LEVEL_O[7:0] >= 8'h80 && ATTEN_LEVEL_O[63:56] >= 8'h80;
	endproperty
	a_floor: assert property (p_floor) else $error("Level below mute");
	property p_zall_set;
		&ZERO_FLAG_O |-> ZERO_ALL_O;
	endproperty
	a_zall_set: assert property (p_zall_set) else $error("All-zero flag low");
	property p_zall_clr;
		ZERO_FLAG_O == 8'h00 |-> !ZERO_ALL_O;
	endproperty
	a_zall_clr: assert property (p_zall_clr) else $error("All-zero flag high");
	property p_oe_idle;
		LATCH_N_I [*6] |-> !SER_DATA_OE_O;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("Driving while idle");
	property p_data_hold;
		SER_CLK_I [*8] |-> $stable(SER_DATA_O);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("Readback moved");
endmodule // adm_bank_chk
bind adm_bank adm_bank_chk #(.ZERO_RUN(ZERO_RUN)) u_chk (
	.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .LATCH_N_I(LATCH_N_I),
	.SER_CLK_I(SER_CLK_I), .STEP_TICK_I(STEP_TICK_I), .SER_DATA_O(SER_DATA_O),
	.SER_DATA_OE_O(SER_DATA_OE_O), .ATTEN_LEVEL_O(ATTEN_LEVEL_O),
	.CHANNEL_OUTPUT_DISABLE_O(CHANNEL_OUTPUT_DISABLE_O),
	.AUDIO_FORMAT_SELECT_O(AUDIO_FORMAT_SELECT_O), .DEEMPH_ENABLE_O(DEEMPH_ENABLE_O),
	.ZERO_FLAG_O(ZERO_FLAG_O), .ZERO_ALL_O(ZERO_ALL_O));
`default_nettype wire

// ===== tb/adm_host.sv
// Host controller model for the serial control port.
// Assumes a free-running system clock; bit clock idles low between frames.
`timescale 1ns/10ps
`default_nettype none
module adm_host (
	input  wire logic clk_i,
	input  wire logic rdata_i,
	input  wire logic rdata_oe_i,
	output var logic  latch_n_o,
	output var logic  ser_clk_o,
	output var logic  ser_data_o
);
	initial begin
		latch_n_o = 1'b1;
		ser_clk_o = 1'b0;
		ser_data_o = 1'b0;
	end
	// Phases of 8 cycles clear the 3-flop filter with margin
	task automatic frame(input logic [15:0] w, input int n, output logic [23:0] r);
		int k;
		r = '0;
		@(negedge clk_i);
		latch_n_o = 1'b0;
		for (k = 0; k < 8 + 8 * n; k++) begin
			ser_data_o = (k < 16) ? w[15 - k] : 1'b0;
			repeat (8) @(negedge clk_i);
			ser_clk_o = 1'b1;
			repeat (8) @(negedge clk_i);
			if (k >= 8) r = {r[22:0], rdata_oe_i ? rdata_i : 1'bx};
			ser_clk_o = 1'b0;
		end
		repeat (8) @(negedge clk_i);
		latch_n_o = 1'b1;
		// Released line must not look like a held value
		ser_data_o = ~ser_data_o;
		repeat (8) @(negedge clk_i);
	endtask
endmodule // adm_host
`default_nettype wire

// ===== tb/audio_dac_mode_control_bank_test.sv
// Testbench for the mode control bank through its serial port.
// Assumes small zero-run count; inputs change at falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module audio_dac_mode_control_bank_test;
	logic clk = 0, rst_n = 0, step = 0, samp = 0;
	// Channel eight programmed below full scale so unmute must restore it
	logic [63:0] tgt = {8'hfe, {7{8'hff}}};
	logic [7:0] cz = 8'h00;
	wire logic latch_n, sclk, sdi, sdo, soe, roll, phase, deen, over, zall, cko;
	wire logic [63:0] lvl;
	wire logic [7:0] dis, zf;
	wire logic [2:0] afs;
	wire logic [1:0] rate;
	logic [23:0] r;
	logic a;
	int error_cnt = 0, check_count = 0;
	logic [6:0] ix [8] = '{7'h07, 7'h08, 7'h09, 7'h0a, 7'h0c, 7'h12, 7'h13, 7'h05};
	logic [7:0] wd [8] = '{8'h3f, 8'h15, 8'h3f, 8'h7f, 8'h80, 8'h03, 8'h02, 8'h55};
	logic [7:0] ex [8] = '{8'h3f, 8'h15, 8'h3f, 8'h7f, 8'h80, 8'h03, 8'h02, 8'h00};
	always #50 clk = ~clk;
	adm_bank #(.ZERO_RUN(4)) dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .LATCH_N_I(latch_n),
		.SER_CLK_I(sclk), .SER_DATA_I(sdi), .SER_DATA_O(sdo), .SER_DATA_OE_O(soe),
		.ATTEN_TARGET_I(tgt), .STEP_TICK_I(step), .SAMPLE_TICK_I(samp),
		.CHANNEL_ZERO_I(cz), .ATTEN_LEVEL_O(lvl), .CHANNEL_OUTPUT_DISABLE_O(dis),
		.FILTER_ROLLOFF_SELECT_O(roll), .AUDIO_FORMAT_SELECT_O(afs),
		.OUTPUT_PHASE_INVERT_O(phase), .DEEMPH_RATE_SELECT_O(rate),
		.DEEMPH_ENABLE_O(deen), .OVERSAMPLE_O(over), .ZERO_FLAG_O(zf),
		.ZERO_ALL_O(zall), .SYSTEM_CLOCK_OUTPUT_O(cko));
	adm_host u_host (.clk_i(clk), .rdata_i(sdo), .rdata_oe_i(soe), .latch_n_o(latch_n),
		.ser_clk_o(sclk), .ser_data_o(sdi));
	task chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [6:0] i, input logic [7:0] d);
		u_host.frame({1'b0, i, d}, 1, r);
	endtask
	task rd(input logic [6:0] i, input logic [7:0] e);
		wr(7'h0b, {1'b0, i});
		u_host.frame({1'b1, i, 8'h00}, 1, r);
		chk(r[7:0], e);
	endtask
	task tick(input bit z, input int n);
		repeat (n) begin
			@(negedge clk);
			samp = z;
			step = !z;
			@(negedge clk);
			samp = 0;
			step = 0;
		end
		repeat (2) @(negedge clk);
	endtask
	task defaults;
		chk(lvl, '1);
		chk({dis, roll, afs, phase, rate, deen, over, zf, zall}, 0);
		@(posedge clk) #5 chk(cko, 1);
	endtask
	task end_of_test;
		if (error_cnt == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		$display("Error %0t: timeout", $time);
		error_cnt++;
		end_of_test;
	end
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1;
		repeat (4) @(negedge clk);
		defaults;
		rd(7'h0b, 8'h0b);
		for (int i = 0; i < 8; i++) begin
			wr(ix[i], wd[i]);
			rd(ix[i], ex[i]);
		end
		chk({dis, roll, afs, phase, rate, deen, over}, {8'h95, 9'h1ff});
		@(posedge clk) #5 chk(cko, 0);
		wr(7'h0b, 8'h89);
		u_host.frame({1'b1, 7'h07, 8'h00}, 3, r);
		chk(r, 24'h3f153f);
		for (int i = 0; i < 8; i++) begin
			wr(7'h09, 8'h10 | i);
			chk({roll, afs}, i);
			@(posedge clk) #5 a = cko;
			@(posedge clk) #5 chk(cko, !a);
		end
		for (int i = 0; i < 8; i++) begin
			wr(7'h0a, {3'b000, i[1:0], i[2:0]});
			chk({rate, deen}, {i[1:0], |i[2:0]});
		end
		wr(7'h07, 8'h01);
		wr(7'h12, 8'h02);
		tick(0, 3);
		chk(lvl, {8'hfc, {6{8'hff}}, 8'hfc});
		wr(7'h07, 8'h00);
		wr(7'h12, 8'h00);
		tick(0, 3);
		chk(lvl, {8'hfe, {7{8'hff}}});
		cz = 8'hff;
		tick(1, 3);
		chk({zf, zall}, 9'h000);
		tick(1, 1);
		chk({zf, zall}, 9'h1ff);
		wr(7'h0a, 8'h40);
		chk({zf, zall}, 9'h000);
		cz = 8'hfe;
		tick(1, 1);
		chk({zf, zall}, 9'h003);
		rst_n = 0;
		repeat (16) @(negedge clk);
		rst_n = 1;
		repeat (4) @(negedge clk);
		defaults;
		end_of_test;
	end
endmodule // audio_dac_mode_control_bank_test
`default_nettype wire
